// *** hdl/sbpf_pkg.sv ***
// Constants, carriers and state codes of the standby, burst and
// protection supervisor.
// Assumes a single 25 MHz clock and comparator flags from analog blocks.
package sbpf_pkg;

	// =====================================================================
	// Clock and time base
	localparam int unsigned CLK_HZ = 25000000;
	localparam int unsigned TICK_US = 100;
	localparam int unsigned TICK_CYCLES = CLK_HZ / 1000000 * TICK_US;
	localparam int unsigned TICKS_PER_S = 1000000 / TICK_US;

	// =====================================================================
	// Line presence
	localparam int unsigned LINE_BLANK_MS = 240;
	localparam int unsigned LINE_BLANK_TICKS = LINE_BLANK_MS * 1000 / TICK_US;
	localparam int unsigned UNPLUG_MAX_MS = 800;
	localparam int unsigned BAND1_MIN_HZ = 47;
	localparam int unsigned BAND1_MAX_HZ = 53;
	localparam int unsigned BAND2_MIN_HZ = 57;
	localparam int unsigned BAND2_MAX_HZ = 63;
	// Period limits in ticks: shortest rounds up, longest rounds down
	localparam logic [7:0] P1_MIN =
		8'((TICKS_PER_S + BAND1_MAX_HZ - 1) / BAND1_MAX_HZ);
	localparam logic [7:0] P1_MAX = 8'(TICKS_PER_S / BAND1_MIN_HZ);
	localparam logic [7:0] P2_MIN =
		8'((TICKS_PER_S + BAND2_MAX_HZ - 1) / BAND2_MAX_HZ);
	localparam logic [7:0] P2_MAX = 8'(TICKS_PER_S / BAND2_MIN_HZ);

	// =====================================================================
	// Burst frequency code: reset value and limits
	localparam logic [7:0] FREQ_RST = 8'h80;
	localparam logic [7:0] FREQ_MIN = 8'h01;
	localparam logic [7:0] FREQ_MAX = 8'hff;

	typedef enum logic [4:0] {
		ST_COLD = 5'h01,
		ST_ACTIVE = 5'h02,
		ST_PAUSE = 5'h04,
		ST_BURST = 5'h08,
		ST_RESTART = 5'h10
	} sbpf_state_t;

	// Comparator flags, each asynchronous to mclk
	typedef struct packed {
		logic fb_below_enter;
		logic fb_at_wake;
		logic fb_at_exit;
		logic supply_above_turn_on;
		logic supply_below_turn_off;
		logic supply_below_wake;
		logic supply_above_overvoltage;
		logic temp_above_trip;
		logic temp_below_release;
	} sbpf_flags_t;

	// Configuration, all times in 100 us ticks
	typedef struct packed {
		logic discharge_enable;
		logic [15:0] burst_blank;
		logic [15:0] burst_on;
		logic [15:0] soft_len;
		logic [15:0] off_target;
		logic [15:0] off_min;
		logic [15:0] restart_break_time;
		logic [15:0] supply_overvoltage_blanking;
	} sbpf_cfg_t;

	typedef struct packed {
		logic pfc_run;
		logic llc_run;
		logic llc_soft;
		logic power_save;
		logic startup_cell;
		logic high_voltage_pin_sink;
		logic line_ok;
		logic [7:0] burst_switching_frequency;
	} sbpf_out_t;

endpackage : sbpf_pkg

// *** hdl/sbpf_sync.sv ***
// Two-flop synchroniser for a vector of independent levels.
// Assumes each bit is a slow level; bits are not coherent with each other.
`timescale 1ns/1ns
`default_nettype none
module sbpf_sync #(
	parameter int W = 1
) (
	input wire logic mclk, // System clock
	input wire logic srst, // Synchronous reset, high
	input wire logic [W-1:0] d, // Asynchronous levels
	output var logic [W-1:0] q // Synchronised levels
);
	logic [W-1:0] meta;

	always_ff @(posedge mclk) begin
		if (srst) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule : sbpf_sync
`default_nettype wire

// *** hdl/sbpf_fsm.sv ***
// Supervisor for line presence, burst standby, supply lockout,
// overvoltage, over-temperature and auto-restart.
// Assumes comparator flags and the line pulse are asynchronous levels and
// that configuration comes from logic on mclk.
// What this block does
// - One regular pulse per line period proves the line present
// - After pulses vanish, wait 240 ms blanking, then enable discharge
// - Unplug recognised well inside 800 ms after alternation stops
// - Recognised unplug turns on the sink cell on the high-voltage pin
// - Discharge feature selectable; disabled means no sink on unplug
// - Pulses count only with period inside 47-53 Hz or 57-63 Hz bands
// - Unplug check acts while in standby
// - Feedback low for entry blanking stops both stages, enters pause
// - Pause wakes on feedback wake level or supply below wake level
// - Burst lasts configured on-time with soft ramp at start and end
// - After a full burst, stop switching and sleep until next wake
// - Burst frequency adapts so off time settles near target
// - Feedback at exit level leaves burst for normal operation
// - Off time down to minimum limit also leaves burst
// - Supply lockout with turn-on and lower turn-off level hysteresis
// - Supply above overvoltage for blanking time enters auto-restart
// - Over-temperature enters auto-restart
// - Break end restarts only if cool, else another break
// - Auto-restart halts stages, sleeps, keeps startup cell on
// - After restart break, begin a fresh start-up
// - Cold start charges supply, goes active above turn-on level
`timescale 1ns/1ns
`default_nettype none
module sbpf_fsm #(
	parameter int unsigned TICK_CYCLES = sbpf_pkg::TICK_CYCLES,
	parameter int unsigned LINE_BLANK_TICKS = sbpf_pkg::LINE_BLANK_TICKS
) (
	input wire logic mclk, // 25 MHz clock
	input wire logic srst, // Synchronous reset, high
	input wire logic multi_function_pin, // Line pulse input
	input wire sbpf_pkg::sbpf_flags_t flags_in, // Raw comparator flags
	input wire sbpf_pkg::sbpf_cfg_t cfg, // Configuration
	output var sbpf_pkg::sbpf_out_t status // Registered controls
);

	// =====================================================================
	// Input synchronisation
	localparam int FW = $bits(sbpf_pkg::sbpf_flags_t);

	sbpf_pkg::sbpf_flags_t fl;
	logic line_s;
	logic [FW:0] raw_in;
	logic [FW:0] sync_out;

	assign raw_in = {multi_function_pin, flags_in};
	assign fl = sync_out[FW-1:0];
	assign line_s = sync_out[FW];

	sbpf_sync #(
		.W(FW + 1)
	) u_sync (
		.mclk(mclk),
		.srst(srst),
		.d(raw_in),
		.q(sync_out)
	);

	// =====================================================================
	// Tick divider
	logic [15:0] div;
	logic tick;

	assign tick = (div == 16'(TICK_CYCLES - 1));

	always_ff @(posedge mclk) begin
		if (srst || tick) begin
			div <= 16'h0000;
		end else begin
			div <= div + 16'h0001;
		end
	end

	// =====================================================================
	// Line presence
	function automatic logic in_band(input logic [7:0] p);
		in_band = (p >= sbpf_pkg::P1_MIN && p <= sbpf_pkg::P1_MAX) ||
			(p >= sbpf_pkg::P2_MIN && p <= sbpf_pkg::P2_MAX);
	endfunction : in_band

	logic line_d;
	logic [7:0] per_cnt;
	logic [15:0] gap_cnt;
	logic line_rise;
	logic good_pulse;
	logic unplug;

	assign line_rise = line_s && !line_d;
	assign good_pulse = line_rise && in_band(per_cnt);
	assign unplug = (gap_cnt >= 16'(LINE_BLANK_TICKS));

	always_ff @(posedge mclk) begin
		if (srst) begin
			line_d <= 1'b0;
			per_cnt <= 8'hff;
		end else begin
			line_d <= line_s;
			if (line_rise) begin
				per_cnt <= 8'h00;
			end else if (tick && per_cnt != 8'hff) begin
				per_cnt <= per_cnt + 8'h01;
			end
		end
	end

	// Gap starts at zero after reset, so with no in-band pulse the sink
	// may fire one blanking interval after reset, once in standby.
	always_ff @(posedge mclk) begin
		if (srst) begin
			gap_cnt <= 16'h0000;
		end else if (good_pulse) begin
			gap_cnt <= 16'h0000;
		end else if (tick && !unplug) begin
			gap_cnt <= gap_cnt + 16'h0001;
		end
	end

	// =====================================================================
	// Supply lockout and faults
	logic supply_on;
	logic [15:0] ovp_cnt;
	logic ovp_trip;
	logic fault;

	always_ff @(posedge mclk) begin
		if (srst) begin
			supply_on <= 1'b0;
		end else if (fl.supply_above_turn_on) begin
			supply_on <= 1'b1;
		end else if (fl.supply_below_turn_off) begin
			supply_on <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst || !fl.supply_above_overvoltage) begin
			ovp_cnt <= 16'h0000;
		end else if (tick && ovp_cnt != 16'hffff) begin
			ovp_cnt <= ovp_cnt + 16'h0001;
		end
	end

	assign ovp_trip = fl.supply_above_overvoltage &&
		(ovp_cnt >= cfg.supply_overvoltage_blanking);
	assign fault = ovp_trip || fl.temp_above_trip;

	// =====================================================================
	// Interval timers
	sbpf_pkg::sbpf_state_t state;
	sbpf_pkg::sbpf_state_t next_state;
	logic [15:0] tmr;
	logic [15:0] blank_cnt;
	logic burst_enter;
	logic wake;
	logic burst_done;
	logic break_end;
	logic restart_again;
	logic in_standby;

	assign burst_enter = fl.fb_below_enter &&
		(blank_cnt >= cfg.burst_blank);
	assign wake = fl.fb_at_wake || fl.supply_below_wake;
	assign burst_done = (tmr >= cfg.burst_on);
	assign break_end = (tmr >= cfg.restart_break_time);
	assign restart_again = (state == sbpf_pkg::ST_RESTART) && supply_on &&
		break_end && !fl.temp_below_release;
	assign in_standby = (state == sbpf_pkg::ST_PAUSE) ||
		(state == sbpf_pkg::ST_BURST);

	always_ff @(posedge mclk) begin
		if (srst || next_state != state || restart_again) begin
			tmr <= 16'h0000;
		end else if (tick && tmr != 16'hffff) begin
			tmr <= tmr + 16'h0001;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst || state != sbpf_pkg::ST_ACTIVE || !fl.fb_below_enter) begin
			blank_cnt <= 16'h0000;
		end else if (tick && blank_cnt != 16'hffff) begin
			blank_cnt <= blank_cnt + 16'h0001;
		end
	end

	// =====================================================================
	// State machine
	always_comb begin
		next_state = state;
		case (state)
			sbpf_pkg::ST_COLD: begin
				if (supply_on) begin
					next_state = sbpf_pkg::ST_ACTIVE;
				end
			end
			sbpf_pkg::ST_ACTIVE: begin
				if (burst_enter) begin
					next_state = sbpf_pkg::ST_PAUSE;
				end
			end
			sbpf_pkg::ST_PAUSE: begin
				if (fl.fb_at_exit) begin
					next_state = sbpf_pkg::ST_ACTIVE;
				end else if (wake && tmr <= cfg.off_min) begin
					next_state = sbpf_pkg::ST_ACTIVE;
				end else if (wake) begin
					next_state = sbpf_pkg::ST_BURST;
				end
			end
			sbpf_pkg::ST_BURST: begin
				if (fl.fb_at_exit) begin
					next_state = sbpf_pkg::ST_ACTIVE;
				end else if (burst_done) begin
					next_state = sbpf_pkg::ST_PAUSE;
				end
			end
			sbpf_pkg::ST_RESTART: begin
				if (break_end && fl.temp_below_release) begin
					next_state = sbpf_pkg::ST_COLD;
				end
			end
			default: begin
				next_state = sbpf_pkg::ST_COLD;
			end
		endcase
		// Lockout outranks faults; outside cold start and restart a fault outranks normal flow
		if (!supply_on) begin
			next_state = sbpf_pkg::ST_COLD;
		end else if (fault && state != sbpf_pkg::ST_COLD &&
			state != sbpf_pkg::ST_RESTART) begin
			next_state = sbpf_pkg::ST_RESTART;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			state <= sbpf_pkg::ST_COLD;
		end else begin
			state <= next_state;
		end
	end

	// =====================================================================
	// Adaptive burst frequency
	// Only nudged once per wake so a noisy off time moves it by one step.
	logic freq_up;
	logic freq_dn;
	logic [7:0] freq;

	assign freq_up = (tmr > cfg.off_target) && freq != sbpf_pkg::FREQ_MAX;
	assign freq_dn = (tmr < cfg.off_target) && freq != sbpf_pkg::FREQ_MIN;

	always_ff @(posedge mclk) begin
		if (srst) begin
			freq <= sbpf_pkg::FREQ_RST;
		end else if (state == sbpf_pkg::ST_PAUSE &&
			next_state == sbpf_pkg::ST_BURST) begin
			if (freq_up) begin
				freq <= freq + 8'h01;
			end else if (freq_dn) begin
				freq <= freq - 8'h01;
			end
		end
	end

	// =====================================================================
	// Registered outputs
	logic nx_run;
	logic nx_soft;
	logic nx_sleep;
	logic nx_cell;
	logic nx_sink;
	logic [16:0] ramp_end;

	assign ramp_end = {1'b0, tmr} + {1'b0, cfg.soft_len};
	assign nx_run = (next_state == sbpf_pkg::ST_ACTIVE) ||
		(next_state == sbpf_pkg::ST_BURST);
	assign nx_soft = (next_state == sbpf_pkg::ST_BURST) &&
		(state != sbpf_pkg::ST_BURST || tmr < cfg.soft_len ||
		ramp_end >= {1'b0, cfg.burst_on});
	assign nx_sleep = (next_state == sbpf_pkg::ST_PAUSE) ||
		(next_state == sbpf_pkg::ST_RESTART);
	assign nx_cell = (next_state == sbpf_pkg::ST_COLD) ||
		(next_state == sbpf_pkg::ST_RESTART);
	assign nx_sink = unplug && cfg.discharge_enable &&
		((next_state == sbpf_pkg::ST_PAUSE) ||
		(next_state == sbpf_pkg::ST_BURST));

	always_ff @(posedge mclk) begin
		if (srst) begin
			status <= '0;
			status.startup_cell <= 1'b1;
			status.burst_switching_frequency <= sbpf_pkg::FREQ_RST;
		end else begin
			status.pfc_run <= nx_run;
			status.llc_run <= nx_run;
			status.llc_soft <= nx_soft;
			status.power_save <= nx_sleep;
			status.startup_cell <= nx_cell;
			status.high_voltage_pin_sink <= nx_sink;
			status.line_ok <= !unplug;
			status.burst_switching_frequency <= freq;
		end
	end

	// =====================================================================
	// Assertions
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	AST_UVLO_COLD: assert property (
		!supply_on |=> state == sbpf_pkg::ST_COLD)
		else $error("lockout did not force cold start");

	AST_COLD_ACTIVE: assert property (
		state == sbpf_pkg::ST_COLD && supply_on
		|=> state == sbpf_pkg::ST_ACTIVE && status.pfc_run)
		else $error("cold start did not reach active");

	AST_OVP_RESTART: assert property (
		state == sbpf_pkg::ST_ACTIVE && supply_on && ovp_trip
		|=> state == sbpf_pkg::ST_RESTART)
		else $error("overvoltage did not enter restart");

	AST_OTP_RESTART: assert property (
		!status.startup_cell && supply_on && fl.temp_above_trip
		|=> state == sbpf_pkg::ST_RESTART)
		else $error("over-temperature did not enter restart");

	AST_RESTART_OUT: assert property (
		state == sbpf_pkg::ST_RESTART |-> !status.pfc_run &&
		!status.llc_run && status.startup_cell && status.power_save)
		else $error("restart outputs wrong");

	AST_BREAK_AGAIN: assert property (
		restart_again |=> state == sbpf_pkg::ST_RESTART && tmr == 16'h0000)
		else $error("hot break end did not start new break");

	AST_SINK_CFG: assert property (
		!cfg.discharge_enable |=> !status.high_voltage_pin_sink)
		else $error("sink on while discharge disabled");

	AST_SINK_STBY: assert property (
		status.high_voltage_pin_sink |-> in_standby && !status.line_ok)
		else $error("sink outside standby or with line present");

	AST_BURST_END: assert property (
		state == sbpf_pkg::ST_BURST && burst_done && supply_on &&
		!fault && !fl.fb_at_exit
		|=> state == sbpf_pkg::ST_PAUSE && !status.llc_run)
		else $error("burst did not end in pause");

	AST_EXIT: assert property (
		state == sbpf_pkg::ST_PAUSE && fl.fb_at_exit && supply_on && !fault
		|=> state == sbpf_pkg::ST_ACTIVE)
		else $error("exit level did not leave standby");

	COV_BURST: cover property (
		state == sbpf_pkg::ST_PAUSE ##1 state == sbpf_pkg::ST_BURST);
	COV_SINK: cover property ($rose(status.high_voltage_pin_sink));
	COV_RECOVER: cover property (
		state == sbpf_pkg::ST_RESTART ##1 state == sbpf_pkg::ST_COLD);

endmodule : sbpf_fsm
`default_nettype wire

// *** bench/sbpf_partner.sv ***
// Line sensing model: one pulse per line period on the multi-function pin.
// Assumes the bench gives the period in ticks of TK clock cycles.
`timescale 1ns/1ns
`default_nettype none
module sbpf_partner #(
	parameter int TK = 4
) (
	input wire logic mclk, // Clock
	input wire logic line_on, // Mains connected
	input wire logic [7:0] period, // Line period in ticks
	output var logic pin // Line pulse
);
	// ==========================================
	// Pulse train
	int cnt = 0;
	// A period in progress runs out, so no pulse is ever cut short
	always @(posedge mclk) begin
		if (!line_on && cnt == 0) begin
			pin <= 1'b0;
		end else begin
			cnt <= (cnt + 1 >= period * TK) ? 0 : cnt + 1;
			pin <= (cnt < 20);
		end
	end
endmodule : sbpf_partner
`default_nettype wire

// *** bench/test_standby_burst_protection_fsm.sv ***
// Self-checking bench for the standby, burst and protection supervisor.
// Assumes the partner model drives the line pulse input.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_fail++; \
	$display("ERROR %0t: got %h want %h", $time, a, b); end end
module test_standby_burst_protection_fsm;
	// ==========================================
	// Signals and instances
	localparam int TK = 4;
	localparam logic [2:0] M_COLD = 3'h1;
	localparam logic [2:0] M_RUN = 3'h4;
	localparam logic [2:0] M_PAUSE = 3'h2;
	localparam logic [2:0] M_RESTART = 3'h3;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic line_on = 1'b0;
	logic [7:0] period = 8'hc8;
	logic mfp;
	sbpf_pkg::sbpf_flags_t flags = '0;
	sbpf_pkg::sbpf_cfg_t cfg;
	sbpf_pkg::sbpf_out_t status;
	logic [2:0] mode;
	int n_fail = 0;
	int checks_done = 0;
	int exp_freq = 128;
	int t;
	logic [31:0] rnd = 32'hf276ab18;
	logic [15:0] bon;
	assign mode = {status.pfc_run, status.power_save, status.startup_cell};
	always #20 mclk = ~mclk;
	sbpf_fsm #(.TICK_CYCLES(TK), .LINE_BLANK_TICKS(300)) dut (.mclk(mclk),
		.srst(srst), .multi_function_pin(mfp), .flags_in(flags),
		.cfg(cfg), .status(status));
	sbpf_partner #(.TK(TK)) line (.mclk(mclk), .line_on(line_on),
		.period(period), .pin(mfp));

	// ==========================================
	// Helpers
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr
	task automatic give_verdict;
		$display("Counts: %0d checks, %0d mismatches", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : give_verdict
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask : cyc
	task automatic wait_mode(input logic [2:0] m, input int bound,
		output int n);
		n = 0;
		while (mode !== m && n < bound) begin
			@(posedge mclk);
			#1;
			n++;
		end
		`CHK(mode, m)
		`CHK(status.llc_run, status.pfc_run)
		if (mode !== m)
			give_verdict();
	endtask : wait_mode
	task automatic wait_line;
		int i;
		logic prev;
		i = 0;
		prev = 1'b1;
		// Ends just after a fresh pulse edge with the line judged present
		while (!(status.line_ok === 1'b1 && mfp === 1'b1 && prev === 1'b0)
			&& i < 1200 * TK) begin
			prev = mfp;
			@(posedge mclk);
			#1;
			i++;
		end
		if (i >= 1200 * TK) begin
			n_fail++;
			$display("ERROR %0t: line pulses not accepted", $time);
			give_verdict();
		end
	endtask : wait_line
	task automatic enter_pause;
		int n;
		flags.fb_at_exit <= 1'b0;
		flags.fb_below_enter <= 1'b1;
		wait_mode(M_PAUSE, 4 * TK + 6, n);
		`CHK(n >= 2 * TK + 1, 1'b1)
		flags.fb_below_enter <= 1'b0;
	endtask : enter_pause
	task automatic do_burst(input bit by_supply, input int off_t,
		input int step);
		int n;
		cyc(off_t * TK);
		if (by_supply)
			flags.supply_below_wake <= 1'b1;
		else
			flags.fb_at_wake <= 1'b1;
		wait_mode(M_RUN, 5, n);
		exp_freq += step;
		`CHK(status.llc_soft, 1'b1)
		flags.supply_below_wake <= 1'b0;
		flags.fb_at_wake <= 1'b0;
		wait_mode(M_PAUSE, 40 * TK, n);
		`CHK(n + TK >= bon * TK && n <= bon * TK + TK + 4, 1'b1)
		// The code output lags the state by a clock; compare once settled
		`CHK(status.burst_switching_frequency, 8'(exp_freq))
		$display("Burst done after %0d off ticks", off_t);
	endtask : do_burst

	// ==========================================
	// Main sequence
	initial begin
		rnd = lfsr(rnd);
		bon = 16'(6 + rnd[2:0]);
		rnd = lfsr(rnd);
		period = 8'(190 + rnd[7:0] % 22);
		cfg = {1'b1, 16'h0003, bon, 16'h0001, 16'h0014, 16'h0002,
			16'h0006, 16'h0004};
		cyc(2);
		srst <= 1'b0;
		cyc(3);
		#1;
		`CHK(mode, M_COLD)
		`CHK(status.burst_switching_frequency, 8'h80)
		flags.supply_above_turn_on <= 1'b1;
		line_on <= 1'b1;
		wait_mode(M_RUN, 5, t);
		$display("Cold start done");
		enter_pause();
		do_burst(1'b0, 40, 1);
		do_burst(1'b1, 10, -1);
		flags.fb_at_exit <= 1'b1;
		wait_mode(M_RUN, 5, t);
		cyc((bon + 4) * TK);
		#1;
		`CHK(mode, M_RUN)
		enter_pause();
		cyc(TK);
		flags.fb_at_wake <= 1'b1;
		wait_mode(M_RUN, 5, t);
		flags.fb_at_wake <= 1'b0;
		cyc((bon + 4) * TK);
		#1;
		`CHK(mode, M_RUN)
		$display("Burst exits done");
		enter_pause();
		wait_line();
		`CHK(status.line_ok, 1'b1)
		line_on <= 1'b0;
		t = 0;
		while (status.high_voltage_pin_sink !== 1'b1 && t < 320 * TK) begin
			@(posedge mclk);
			#1;
			t++;
		end
		`CHK(t >= 299 * TK, 1'b1)
		`CHK(t <= 302 * TK + 6, 1'b1)
		`CHK(status.high_voltage_pin_sink, 1'b1)
		if (t >= 320 * TK)
			give_verdict();
		`CHK(status.line_ok, 1'b0)
		flags.fb_at_exit <= 1'b1;
		wait_mode(M_RUN, 5, t);
		cyc(2);
		#1;
		`CHK(status.high_voltage_pin_sink, 1'b0)
		cfg.discharge_enable <= 1'b0;
		enter_pause();
		cyc(2);
		#1;
		`CHK(status.high_voltage_pin_sink, 1'b0)
		period <= 8'ha7;
		line_on <= 1'b1;
		wait_line();
		`CHK(status.line_ok, 1'b1)
		flags.fb_at_exit <= 1'b1;
		wait_mode(M_RUN, 5, t);
		// Pulses outside both bands must not hold off the unplug verdict
		cfg.discharge_enable <= 1'b1;
		period <= 8'h78;
		enter_pause();
		t = 0;
		while (status.high_voltage_pin_sink !== 1'b1 && t < 480 * TK) begin
			@(posedge mclk);
			#1;
			t++;
		end
		`CHK(status.high_voltage_pin_sink, 1'b1)
		if (t >= 480 * TK)
			give_verdict();
		period <= 8'ha7;
		flags.fb_at_exit <= 1'b1;
		wait_mode(M_RUN, 5, t);
		`CHK(status.high_voltage_pin_sink, 1'b0)
		$display("Unplug done");
		flags.supply_above_overvoltage <= 1'b1;
		wait_mode(M_RESTART, 5 * TK + 6, t);
		`CHK(t >= 3 * TK + 1, 1'b1)
		flags.supply_above_overvoltage <= 1'b0;
		cyc(14 * TK);
		#1;
		`CHK(mode, M_RESTART)
		flags.temp_below_release <= 1'b1;
		wait_mode(M_RUN, 8 * TK + 8, t);
		flags.temp_above_trip <= 1'b1;
		wait_mode(M_RESTART, 5, t);
		flags.temp_above_trip <= 1'b0;
		wait_mode(M_RUN, 8 * TK + 8, t);
		$display("Protection done");
		flags.supply_above_turn_on <= 1'b0;
		flags.supply_below_turn_off <= 1'b1;
		wait_mode(M_COLD, 5, t);
		flags.supply_below_turn_off <= 1'b0;
		cyc(4 * TK);
		#1;
		`CHK(mode, M_COLD)
		flags.supply_above_turn_on <= 1'b1;
		wait_mode(M_RUN, 5, t);
		$display("Lockout done");
		give_verdict();
	end
endmodule : test_standby_burst_protection_fsm
`default_nettype wire
